// ---- hdl/wdr_pkg.sv ----
package wdr_pkg;

   // register byte addresses on the Avalon slave
   localparam logic [3:0] ADDR_FLAGS = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // reset cause flags, bit 4 down to bit 0
   typedef struct packed {
      logic scan;
      logic watchdog;
      logic brownout;
      logic pin;
      logic poweron;
   } wdr_causes_t;

   localparam wdr_causes_t CAUSES_RESET = 5'h00;

   // control register, bit 4 down to bit 0; bits 7..5 read zero
   typedef struct packed {
      logic changeEnable;
      logic enable;
      logic [2:0] period;
   } wdr_ctrl_t;

   localparam logic [2:0] PERIOD_RESET = 3'h0;

   // safety level decoded from the two fuses
   typedef enum logic [2:0] {
      LVL0 = 3'b001,
      LVL1 = 3'b010,
      LVL2 = 3'b100
   } wdr_level_t;

   // change window length in core cycles
   localparam int CE_W = 3;
   localparam logic [CE_W-1:0] CE_WINDOW_CYCLES = 3'h4;
   localparam logic [CE_W-1:0] CE_IDLE = 3'h0;
   localparam logic [CE_W-1:0] CE_STEP = 3'h1;

   // watchdog oscillator and timeout counter
   localparam int WDT_OSC_FREQ_HZ = 1000000;
   localparam int COUNT_W = 22;
   localparam logic [COUNT_W-1:0] WDT_BASE_CYCLES = 22'h004000;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 22'h000000;
   localparam logic [COUNT_W-1:0] COUNT_STEP = 22'h000001;

   // synchronised input bundle
   localparam int SYNC_W = 7;

endpackage

// ---- hdl/wdr_sync.sv ----
`timescale 1ns/1ps
module wdr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1;

   // stage1 feeds only the second flop
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage1 <= '0;
         syncOut <= '0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule // wdr_sync

// ---- hdl/wdr_cause_flag.sv ----
`timescale 1ns/1ps
module wdr_cause_flag (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic implemented,
   input wire logic setEvent,
   input wire logic clearEvent,
   input wire logic swClear,
   output logic flag
);

   // set wins over any clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (!implemented) begin
         flag <= 1'b0;
      end else if (setEvent) begin
         flag <= 1'b1;
      end else if (clearEvent || swClear) begin
         flag <= 1'b0;
      end
   end

endmodule // wdr_cause_flag

// ---- hdl/wdr_watchdog.sv ----
`timescale 1ns/1ps
// Functional notes
// - scan reset sets bit 4; brown-out or software zero clears it.
// - watchdog reset sets bit 3; power-on or software zero clears it.
// - brown-out reset sets bit 2; power-on or software zero clears it.
// - pin reset sets bit 1; power-on or software zero clears it.
// - power-on sets bit 0; only a software zero clears it.
// - legacy fuse leaves only pin and power-on flags working.
// - counter advances on the separate 1 MHz watchdog oscillator.
// - count restarts on restart command, when disabled, and on chip reset.
// - enabled watchdog reaching its period without restart resets the chip.
// - fuses decode to safety level 0, 1 or 2.
// - levels 0 and 1 start disabled; level 2 is always enabled.
// - one write of enable one enables at every level.
// - above level 0 the period changes only inside the change window.
// - hardware drops change-enable four core cycles after it is written.
// - enable zero takes effect only while change-enable is one.
// - control bits 7 to 5 read as zero.
// - timeout is 16384 oscillator cycles doubled per period code step.
// - timeout gives a one core cycle reset pulse.
// - at level 2 the enable bit reads one.
module wdr_watchdog #(
   parameter logic [wdr_pkg::COUNT_W-1:0] TIMEOUT_BASE = wdr_pkg::WDT_BASE_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [wdr_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [wdr_pkg::DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [wdr_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic wdtOsc,
   input wire logic wdtRestart,
   input wire logic poweronResetIn,
   input wire logic brownoutResetIn,
   input wire logic pinResetIn,
   input wire logic scanResetIn,
   input wire logic legacyCompatFuse,
   input wire logic alwaysOnFuse,
   output logic watchdogReset
);

   logic [wdr_pkg::SYNC_W-1:0] syncIn;
   logic [wdr_pkg::SYNC_W-1:0] syncOut;
   logic oscLevel;
   logic oscPrev;
   logic tickEdge;
   wdr_pkg::wdr_causes_t srcActive;
   logic compatFuse;
   logic onFuse;
   wdr_pkg::wdr_level_t level;
   logic chipReset;

   logic busAck;
   logic wrStrobe;
   logic flagWr;
   logic ctrlWr;
   wdr_pkg::wdr_causes_t wrFlags;
   wdr_pkg::wdr_ctrl_t wrCtrl;
   logic [wdr_pkg::DATA_W-1:0] readValue;

   logic [wdr_pkg::CE_W-1:0] ceCount;
   logic changeEnable;
   logic ceLoad;
   logic enable;
   logic effEnable;
   logic [2:0] period;
   logic periodUnlocked;
   wdr_pkg::wdr_ctrl_t ctrlRead;

   logic [wdr_pkg::COUNT_W-1:0] count;
   logic [wdr_pkg::COUNT_W-1:0] limit;
   logic timeoutHit;

   wdr_pkg::wdr_causes_t flags;
   wdr_pkg::wdr_causes_t flagImpl;
   wdr_pkg::wdr_causes_t swClear;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // every pin-side level passes two flops
   assign syncIn = {wdtOsc, scanResetIn, brownoutResetIn, pinResetIn, poweronResetIn,
                    legacyCompatFuse, alwaysOnFuse};

   wdr_sync #(
      .WIDTH(wdr_pkg::SYNC_W)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .asyncIn(syncIn),
      .syncOut(syncOut)
   );

   assign oscLevel = syncOut[6];
   assign srcActive.scan = syncOut[5];
   assign srcActive.brownout = syncOut[4];
   assign srcActive.pin = syncOut[3];
   assign srcActive.poweron = syncOut[2];
   assign srcActive.watchdog = watchdogReset;
   assign compatFuse = syncOut[1];
   assign onFuse = syncOut[0];

   // oscillator sampled as a tick; core clock must exceed twice its rate
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         oscPrev <= 1'b0;
      end else begin
         oscPrev <= oscLevel;
      end
   end

   assign tickEdge = oscLevel & ~oscPrev;

   always_comb begin
      if (onFuse) begin
         level = wdr_pkg::LVL2;
      end else if (compatFuse) begin
         level = wdr_pkg::LVL0;
      end else begin
         level = wdr_pkg::LVL1;
      end
   end

   // any reset source, or our own pulse, resets the watchdog logic
   assign chipReset = srcActive.scan | srcActive.brownout | srcActive.pin | srcActive.poweron | watchdogReset;

   // one wait state: request seen, then answered
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busAck <= 1'b0;
      end else begin
         busAck <= (read | write) & ~busAck;
      end
   end

   assign waitrequest = (read | write) & ~busAck;
   assign wrStrobe = write & busAck & byteenable[0];
   assign flagWr = wrStrobe && (address == wdr_pkg::ADDR_FLAGS);
   assign ctrlWr = wrStrobe && (address == wdr_pkg::ADDR_CTRL);
   assign wrFlags = writedata[$bits(wdr_pkg::wdr_causes_t)-1:0];
   assign wrCtrl = writedata[$bits(wdr_pkg::wdr_ctrl_t)-1:0];

   assign ctrlRead.changeEnable = changeEnable;
   assign ctrlRead.enable = effEnable;
   assign ctrlRead.period = period;

   // upper bits, control bits 7..5 among them, read zero
   always_comb begin
      readValue = '0;
      if (address == wdr_pkg::ADDR_FLAGS) begin
         readValue[$bits(wdr_pkg::wdr_causes_t)-1:0] = flags;
      end else if (address == wdr_pkg::ADDR_CTRL) begin
         readValue[$bits(wdr_pkg::wdr_ctrl_t)-1:0] = ctrlRead;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         readdata <= '0;
      end else if (read && !busAck) begin
         readdata <= readValue;
      end
   end

   // change window: any write of change-enable one reopens it
   assign ceLoad = ctrlWr & wrCtrl.changeEnable;

   always_ff @(posedge ref_clk) begin
      if (rst || chipReset) begin
         ceCount <= wdr_pkg::CE_IDLE;
      end else if (ceLoad) begin
         ceCount <= wdr_pkg::CE_WINDOW_CYCLES;
      end else if (ceCount != wdr_pkg::CE_IDLE) begin
         ceCount <= ceCount - wdr_pkg::CE_STEP;
      end
   end

   // software must finish its sequence while this is high
   assign changeEnable = (ceCount != wdr_pkg::CE_IDLE);

   always_ff @(posedge ref_clk) begin
      if (rst || chipReset) begin
         enable <= 1'b0;
      end else if (ctrlWr) begin
         if (wrCtrl.enable) begin
            enable <= 1'b1;
         end else if (changeEnable && level != wdr_pkg::LVL2) begin
            enable <= 1'b0;
         end
      end
   end

   assign effEnable = enable | (level == wdr_pkg::LVL2);

   always_comb begin
      unique case (level)
         wdr_pkg::LVL0: periodUnlocked = 1'b1;
         wdr_pkg::LVL1: periodUnlocked = changeEnable;
         wdr_pkg::LVL2: periodUnlocked = changeEnable;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst || chipReset) begin
         period <= wdr_pkg::PERIOD_RESET;
      end else if (ctrlWr && periodUnlocked) begin
         period <= wrCtrl.period;
      end
   end

   assign limit = TIMEOUT_BASE << period;
   // compare with >= so a shortened period still fires on the next oscillator tick
   assign timeoutHit = effEnable && tickEdge && (count >= limit - wdr_pkg::COUNT_STEP);

   always_ff @(posedge ref_clk) begin
      if (rst || chipReset || wdtRestart || !effEnable) begin
         count <= wdr_pkg::COUNT_ZERO;
      end else if (tickEdge) begin
         count <= count + wdr_pkg::COUNT_STEP;
      end
   end

   // the pulse itself clears the counter next cycle; the single-cycle tickEdge keeps it to one cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         watchdogReset <= 1'b0;
      end else begin
         watchdogReset <= timeoutHit;
      end
   end

   assign flagImpl.scan = ~compatFuse;
   assign flagImpl.watchdog = ~compatFuse;
   assign flagImpl.brownout = ~compatFuse;
   assign flagImpl.pin = 1'b1;
   assign flagImpl.poweron = 1'b1;
   // a one written leaves the flag alone
   assign swClear = flagWr ? ~wrFlags : wdr_pkg::CAUSES_RESET;

   wdr_cause_flag u_flag_scan (
      .ref_clk(ref_clk),
      .rst(rst),
      .implemented(flagImpl.scan),
      .setEvent(srcActive.scan),
      .clearEvent(srcActive.brownout),
      .swClear(swClear.scan),
      .flag(flags.scan)
   );

   wdr_cause_flag u_flag_watchdog (
      .ref_clk(ref_clk),
      .rst(rst),
      .implemented(flagImpl.watchdog),
      .setEvent(srcActive.watchdog),
      .clearEvent(srcActive.poweron),
      .swClear(swClear.watchdog),
      .flag(flags.watchdog)
   );

   wdr_cause_flag u_flag_brownout (
      .ref_clk(ref_clk),
      .rst(rst),
      .implemented(flagImpl.brownout),
      .setEvent(srcActive.brownout),
      .clearEvent(srcActive.poweron),
      .swClear(swClear.brownout),
      .flag(flags.brownout)
   );

   wdr_cause_flag u_flag_pin (
      .ref_clk(ref_clk),
      .rst(rst),
      .implemented(flagImpl.pin),
      .setEvent(srcActive.pin),
      .clearEvent(srcActive.poweron),
      .swClear(swClear.pin),
      .flag(flags.pin)
   );

   wdr_cause_flag u_flag_poweron (
      .ref_clk(ref_clk),
      .rst(rst),
      .implemented(flagImpl.poweron),
      .setEvent(srcActive.poweron),
      .clearEvent(1'b0),
      .swClear(swClear.poweron),
      .flag(flags.poweron)
   );

   a_ce_window_open: assert property (ceLoad && !chipReset |=> changeEnable [*4])
      else $error("change window shorter than four cycles");

   a_ce_window_close: assert property ((ceLoad ##1 !ceLoad [*4]) |=> !changeEnable)
      else $error("change window not closed after four cycles");

   a_reset_pulse_len: assert property (watchdogReset |=> !watchdogReset)
      else $error("watchdog reset pulse longer than one cycle");

   a_timeout_cause: assert property ($rose(watchdogReset) |-> $past(timeoutHit))
      else $error("watchdog reset without a timeout");

   a_count_restart: assert property ((wdtRestart || !effEnable) |=> count == wdr_pkg::COUNT_ZERO)
      else $error("count not restarted");

   a_level2_enable: assert property (level == wdr_pkg::LVL2 |-> readValue[3] || address != wdr_pkg::ADDR_CTRL)
      else $error("enable reads zero at level 2");

   a_enable_hold: assert property (ctrlWr && !wrCtrl.enable && !changeEnable && !chipReset
                                   |=> enable == $past(enable))
      else $error("enable cleared outside the change window");

   a_period_locked: assert property (ctrlWr && !changeEnable && level != wdr_pkg::LVL0 && !chipReset
                                     |=> period == $past(period))
      else $error("period changed while locked");

   a_wdt_flag_set: assert property (watchdogReset && !compatFuse |=> flags.watchdog)
      else $error("watchdog flag not set by timeout");

   a_por_flag_sticky: assert property ($fell(flags.poweron) |-> $past(swClear.poweron))
      else $error("power-on flag cleared without a software zero");

   a_legacy_flags: assert property (compatFuse ##1 compatFuse |-> !flags.scan && !flags.watchdog)
      else $error("unavailable flag set in legacy mode");

   c_timeout: cover property (watchdogReset);
   c_disable_seq: cover property (ceLoad ##[1:4] (ctrlWr && !wrCtrl.enable) ##1 !enable);
   c_period_change: cover property (ctrlWr && changeEnable && level == wdr_pkg::LVL1 ##1 period != $past(period));
   c_flag_clear: cover property (flags.pin ##1 !flags.pin);

endmodule // wdr_watchdog

// ---- test/tb_wdr_watchdog.sv ----
`timescale 1ns/1ps
module tb_wdr_watchdog;
   localparam logic [3:0] CT = wdr_pkg::ADDR_CTRL;
   localparam logic [3:0] FL = wdr_pkg::ADDR_FLAGS;
   logic ref_clk = 1'b0;
   logic rst, read, write, wdtOsc, wdtRestart, lc, ao, waitrequest, watchdogReset;
   logic prevWr = 1'b0;
   logic [3:0] address, byteenable, src, be, a;
   logic [31:0] writedata, readdata, rdv, d;
   logic en;
   logic [2:0] per;
   int n_fail, n_tests, pulses, cyc, base;

   // small base keeps the longest period at 512 oscillator ticks
   wdr_watchdog #(.TIMEOUT_BASE(22'h000004)) i_wdr_watchdog (.ref_clk(ref_clk), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .wdtOsc(wdtOsc), .wdtRestart(wdtRestart), .poweronResetIn(src[0]),
      .brownoutResetIn(src[1]), .pinResetIn(src[2]), .scanResetIn(src[3]), .legacyCompatFuse(lc),
      .alwaysOnFuse(ao), .watchdogReset(watchdogReset));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one spare edge before raising keeps strobes from toggling twice in a step
   task automatic bus(input logic rd, input logic [3:0] ad, input logic [31:0] dt, input logic [3:0] bn);
      int k;
      @(posedge ref_clk);
      address <= ad;
      writedata <= dt;
      byteenable <= bn;
      read <= rd;
      write <= !rd;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         n_fail++;
         $display("[FAIL] waitrequest expected 0 seen 1");
         end_sim;
      end
      rdv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
      bus(1'b0, ad, dt, 4'hF);
   endtask

   task automatic rdc(input logic [3:0] ad, input logic [31:0] exp, input string name);
      bus(1'b1, ad, 32'h0, 4'hF);
      chk(name, exp, rdv);
   endtask

   // sources are levels; hold long enough to pass the synchroniser
   task automatic pulse_src(input int b);
      src <= 4'(1 << b);
      idle(3);
      src <= 4'h0;
      idle(6);
   endtask

   // oscillator well below half the core rate so every edge is seen
   task automatic tick(input int n);
      repeat (n) begin
         wdtOsc <= 1'b1;
         idle(10);
         wdtOsc <= 1'b0;
         idle(10);
      end
   endtask

   task automatic set_level(input logic l, input logic o);
      lc <= l;
      ao <= o;
      rst <= 1'b1;
      idle(20);
      rst <= 1'b0;
      idle(4);
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (watchdogReset === 1'b1) begin
         pulses++;
      end
      if (prevWr === 1'b1) begin
         chk("single cycle pulse", 32'h0, {31'h0, watchdogReset});
      end
      prevWr <= watchdogReset;
      if (cyc > 90000) begin
         n_fail++;
         $display("[FAIL] run length expected end seen hang");
         end_sim;
      end
   end

   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      byteenable = 4'h0;
      wdtOsc = 1'b0;
      wdtRestart = 1'b0;
      src = 4'h0;
      lc = 1'b0;
      ao = 1'b0;
      n_fail = 0;
      n_tests = 0;
      pulses = 0;
      cyc = 0;
      void'($urandom(32'hF2CE05A3));
      set_level(1'b0, 1'b0);
      rdc(CT, 32'h0, "ctrl after reset");
      rdc(FL, 32'h0, "flags after reset");
      rdc(4'h8, 32'h0, "unmapped read");
      wr(CT, 32'hFFFFFFE7);
      rdc(CT, 32'h0, "period outside window");
      wr(CT, 32'h08);
      rdc(CT, 32'h08, "single enable write");
      wr(CT, 32'h00);
      rdc(CT, 32'h08, "disable without window");
      wr(CT, 32'h18);
      rdc(CT, 32'h18, "window open");
      idle(4);
      rdc(CT, 32'h08, "window closed");
      wr(CT, 32'h18);
      idle(1);
      wr(CT, 32'h0B);
      rdc(CT, 32'h0B, "last window cycle");
      wr(CT, 32'h18);
      idle(2);
      wr(CT, 32'h00);
      rdc(CT, 32'h0B, "one cycle late");
      wr(CT, 32'h18);
      wr(CT, 32'h00);
      idle(4);
      rdc(CT, 32'h00, "disable sequence");
      wr(CT, 32'h08);
      pulse_src(3);
      rdc(CT, 32'h00, "ctrl after chip reset");
      rdc(FL, 32'h10, "scan flag");
      pulse_src(2);
      rdc(FL, 32'h12, "pin flag");
      wr(FL, 32'h1F);
      rdc(FL, 32'h12, "write ones");
      pulse_src(1);
      rdc(FL, 32'h06, "brownout flag");
      pulse_src(0);
      rdc(FL, 32'h01, "poweron flag");
      pulse_src(3);
      pulse_src(0);
      rdc(FL, 32'h11, "poweron keeps scan");
      wr(FL, 32'h10);
      rdc(FL, 32'h10, "sw clear poweron");
      wr(FL, 32'h00);
      rdc(FL, 32'h00, "sw clear scan");
      wr(CT, 32'h08);
      tick(3);
      wdtRestart <= 1'b1;
      idle(2);
      wdtRestart <= 1'b0;
      tick(3);
      chk("no reset after restart", 32'h0, 32'(pulses));
      tick(1);
      chk("timeout pulse", 32'h1, 32'(pulses));
      rdc(FL, 32'h08, "watchdog flag");
      rdc(CT, 32'h00, "ctrl after timeout");
      pulse_src(0);
      rdc(FL, 32'h01, "poweron clears watchdog");
      // level 0: legacy fuse
      set_level(1'b1, 1'b0);
      pulse_src(3);
      pulse_src(1);
      pulse_src(2);
      rdc(FL, 32'h02, "legacy flags");
      en = 1'b0;
      per = 3'h0;
      repeat (12) begin
         d = $urandom;
         be = 4'($urandom);
         a = 4'($urandom);
         d[4] = 1'b0;
         bus(1'b0, CT, d, be);
         if (be[0]) begin
            en = en | d[3];
            per = d[2:0];
         end
         rdc(CT, {27'h0, 1'b0, en, per}, "ctrl random");
         if (a != CT && a != FL) begin
            wr(a, d);
            rdc(a, 32'h0, "unmapped random");
         end
      end
      for (int p = 0; p < 8; p++) begin
         wr(CT, 32'h08 | p);
         base = pulses;
         tick((4 << p) - 1);
         chk("no early timeout", 32'(base), 32'(pulses));
         tick(1);
         chk("period timeout", 32'(base + 1), 32'(pulses));
      end
      rdc(FL, 32'h02, "legacy no watchdog flag");
      // level 2: always on
      set_level(1'b0, 1'b1);
      rdc(CT, 32'h08, "starts enabled");
      wr(CT, 32'h01);
      rdc(CT, 32'h08, "period locked");
      wr(CT, 32'h18);
      wr(CT, 32'h00);
      idle(4);
      rdc(CT, 32'h08, "cannot disable");
      wr(CT, 32'h18);
      wr(CT, 32'h01);
      idle(4);
      rdc(CT, 32'h09, "period in window");
      base = pulses;
      tick(7);
      chk("level 2 early", 32'(base), 32'(pulses));
      tick(1);
      chk("level 2 timeout", 32'(base + 1), 32'(pulses));
      rdc(CT, 32'h08, "enable after timeout");
      end_sim;
   end
endmodule // tb_wdr_watchdog
